// >>> core/osff_framer.sv
// drive-side sector framer: parses media bytes into the read link, gates write data
`timescale 1ns/1ps
module osff_framer (
    input wire logic clk, // system clock, 250 MHz
    input wire logic sys_rst, // synchronous reset
    input wire logic index_pin, // index pulse from spindle
    input wire logic sector_pin, // sector pulse from spindle
    input wire logic read_gate_pin, // read gate from controller
    input wire logic write_gate_pin, // write gate from controller
    input wire logic [7:0] media_byte, // decoded byte from media
    input wire logic media_valid, // one media byte this cycle
    input wire logic [7:0] wr_byte, // write data from controller
    input wire logic wwid_en, // media carries identifier field
    input wire logic addr_chk_hide, // drive guarantees address integrity
    input wire logic cfg_req, // configuration length request
    input wire osff_pkg::osff_state_t cfg_sel, // field being queried
    output logic [7:0] rd_byte, // read data to controller
    output logic rd_valid, // read byte strobe
    output logic addr_mark, // address sync presented
    output logic data_mark, // recording pattern presented
    output logic synth_used, // last mark was synthesized
    output logic defect_sector, // write status byte nonzero
    output logic write_abort, // write refused on defective sector
    output logic [7:0] media_wr_byte, // byte to recording channel
    output logic media_wr_en, // recording enable
    output logic [7:0] sector_num, // sector count since index
    output logic cfg_ack, // configuration answer strobe
    output logic [15:0] cfg_len // configured field length
);
    import osff_pkg::*;

    // ----------------------------------------------------------------
    // field length lookup
    // ----------------------------------------------------------------
    function automatic logic [15:0] fld_len(input osff_state_t s, input logic wid);
        logic [15:0] n;
        n = 16'h0001;
        case (s)
            S_APLO: n = ADDR_PLO_LEN;
            S_ASYNC: n = ADDR_SYNC_WIN;
            S_ABODY: n = wid ? ABODY_LEN_W : ABODY_LEN_N; // see RULE9
            S_ACHK: n = ADDR_CHK_LEN;
            S_AWST: n = WSTAT_LEN;
            S_APAD: n = ADDR_PAD_LEN;
            S_DSPL: n = SPLICE_LEN;
            S_DPLO: n = DATA_PLO_LEN;
            S_DPAT: n = DATA_PAT_WIN;
            S_DDATA: n = SEG_DATA_LEN; // see RULE20
            S_DCHK: n = SEG_CHK_LEN;
            S_DPAD: n = DATA_PAD_LEN;
            default: n = 16'h0001;
        endcase
        return n;
    endfunction : fld_len

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pins_s;
    logic idx_s;
    logic sec_s;
    logic rg_s;
    logic wg_s;

    osff_pin_sync #(.W(4)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({write_gate_pin, read_gate_pin, sector_pin, index_pin}),
        .pin_out(pins_s)
    );

    assign idx_s = pins_s[0];
    assign sec_s = pins_s[1];
    assign rg_s = pins_s[2];
    assign wg_s = pins_s[3];

    // ----------------------------------------------------------------
    // state and counters
    // ----------------------------------------------------------------
    osff_state_t state_r;
    osff_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0] seg_r;
    logic [7:0] seg_nxt;
    logic idx_q_r;
    logic sec_q_r;
    logic [7:0] sec_cnt_r;
    logic [7:0] sec_cnt_nxt;
    logic miss_vld_r;
    logic miss_vld_nxt;
    logic [7:0] miss_sec_r;
    logic [7:0] wstat_r;
    logic [7:0] wstat_nxt;

    // pulse and decode wires
    logic idx_rise;
    logic sec_rise;
    logic last_byte;
    logic addr_hit;
    logic addr_synth;
    logic pat_hit;
    logic pass_state;
    logic chk_hidden;
    logic defect;
    logic in_data_area;
    logic abort_nxt;
    logic [7:0] rd_byte_nxt;
    logic rd_valid_nxt;
    logic addr_mark_nxt;
    logic data_mark_nxt;
    logic synth_nxt;
    logic miss_now;

    // edge detection on filtered pins
    assign idx_rise = idx_s & ~idx_q_r;
    assign sec_rise = sec_s & ~sec_q_r;
    assign last_byte = media_valid & (cnt_r == 16'h0001);

    // address sync: real match, or synthesized for a previously missed sector
    assign addr_hit = (state_r == S_ASYNC) & media_valid & (media_byte == ADDR_SYNC_PAT); // see RULE6
    assign addr_synth = (state_r == S_ASYNC) & media_valid & miss_vld_r
        & (miss_sec_r == sec_cnt_r); // see RULE7
    assign miss_now = (state_r == S_ASYNC) & last_byte & ~addr_hit & ~addr_synth;

    // recording pattern match
    assign pat_hit = (state_r == S_DPAT) & media_valid & (media_byte == DATA_PAT);

    // states whose bytes pass to the read link
    assign pass_state = (state_r == S_ABODY) | (state_r == S_ACHK) | (state_r == S_AWST)
        | (state_r == S_DDATA) | (state_r == S_DCHK);
    assign chk_hidden = (state_r == S_ACHK) & addr_chk_hide; // see RULE11

    // defective sector and data area window for write refusal
    assign defect = (wstat_r != 8'h00); // see RULE12
    assign in_data_area = (state_r == S_DSPL) | (state_r == S_DPLO) | (state_r == S_DPAT)
        | (state_r == S_DDATA) | (state_r == S_DCHK) | (state_r == S_DPAD);
    assign abort_nxt = wg_s & defect & (in_data_area | write_abort); // see RULE13

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        seg_nxt = seg_r;
        if (state_r == S_IDLE) begin
            if (sec_rise & rg_s) begin // see RULE1
                state_nxt = S_APLO;
                cnt_nxt = fld_len(S_APLO, wwid_en);
            end
        end else if (~rg_s & ~wg_s) begin
            state_nxt = S_IDLE;
        end else if (state_r == S_ASYNC) begin
            if (addr_hit | addr_synth) begin
                state_nxt = S_ABODY;
                cnt_nxt = fld_len(S_ABODY, wwid_en);
            end else if (last_byte) begin
                state_nxt = S_IDLE; // sector lost this revolution
            end else if (media_valid) begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end else if (state_r == S_DPAT) begin
            if (pat_hit | last_byte) begin // see RULE19
                state_nxt = S_DDATA;
                cnt_nxt = fld_len(S_DDATA, wwid_en);
                seg_nxt = 8'h00;
            end else if (media_valid) begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end else if (last_byte) begin
            case (state_r)
                S_APLO: state_nxt = S_ASYNC;
                S_ABODY: state_nxt = S_ACHK;
                S_ACHK: state_nxt = S_AWST;
                S_AWST: state_nxt = S_APAD;
                S_APAD: state_nxt = S_DSPL;
                S_DSPL: state_nxt = (DATA_PLO_LEN == 16'h0000) ? S_DPAT : S_DPLO; // see RULE16
                S_DPLO: state_nxt = S_DPAT;
                S_DDATA: state_nxt = S_DCHK;
                S_DCHK: state_nxt = (seg_r == SEG_NUM - 8'h01) ? S_DPAD : S_DDATA; // see RULE20
                S_DPAD: state_nxt = S_IDLE;
                default: state_nxt = S_IDLE;
            endcase
            cnt_nxt = fld_len(state_nxt, wwid_en); // see RULE3
            if (state_r == S_DCHK) begin
                seg_nxt = seg_r + 8'h01;
            end
        end else if (media_valid) begin
            cnt_nxt = cnt_r - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // sector count and missed sync memory
    // ----------------------------------------------------------------
    assign sec_cnt_nxt = idx_rise ? 8'h00 : (sec_rise ? sec_cnt_r + 8'h01 : sec_cnt_r);
    assign miss_vld_nxt = miss_now | (miss_vld_r & ~addr_synth); // see RULE7

    // write status byte captured as it passes
    assign wstat_nxt = (state_r == S_APLO) ? 8'h00
        : ((state_r == S_AWST) & media_valid) ? media_byte : wstat_r;

    // ----------------------------------------------------------------
    // read link byte selection
    // ----------------------------------------------------------------
    assign rd_byte_nxt = (addr_hit | addr_synth) ? ADDR_SYNC_PAT
        : (state_r == S_DPAT) ? DATA_PAT : media_byte;
    assign rd_valid_nxt = (pass_state & media_valid & ~chk_hidden)
        | addr_hit | addr_synth | pat_hit | ((state_r == S_DPAT) & last_byte);
    assign addr_mark_nxt = addr_hit | addr_synth;
    assign data_mark_nxt = pat_hit | ((state_r == S_DPAT) & last_byte);
    assign synth_nxt = (addr_synth & ~addr_hit) | ((state_r == S_DPAT) & last_byte & ~pat_hit);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            cnt_r <= 16'h0000;
            seg_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            seg_r <= seg_nxt;
        end
    end

    // pin edges and sector position
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idx_q_r <= 1'b0;
            sec_q_r <= 1'b0;
            sec_cnt_r <= 8'h00;
        end else begin
            idx_q_r <= idx_s;
            sec_q_r <= sec_s;
            sec_cnt_r <= sec_cnt_nxt;
        end
    end

    // missed sync and write status memory
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            miss_vld_r <= 1'b0;
            miss_sec_r <= 8'h00;
            wstat_r <= 8'h00;
        end else begin
            miss_vld_r <= miss_vld_nxt;
            miss_sec_r <= miss_now ? sec_cnt_r : miss_sec_r;
            wstat_r <= wstat_nxt;
        end
    end

    // read link outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_byte <= 8'h00;
            rd_valid <= 1'b0;
            addr_mark <= 1'b0;
            data_mark <= 1'b0;
        end else begin
            rd_byte <= rd_byte_nxt;
            rd_valid <= rd_valid_nxt;
            addr_mark <= addr_mark_nxt;
            data_mark <= data_mark_nxt;
        end
    end

    // status outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            synth_used <= 1'b0;
            defect_sector <= 1'b0;
            write_abort <= 1'b0;
            sector_num <= 8'h00;
        end else begin
            synth_used <= (addr_mark_nxt | data_mark_nxt) ? synth_nxt : synth_used;
            defect_sector <= defect;
            write_abort <= abort_nxt;
            sector_num <= sec_cnt_r;
        end
    end

    // recording channel: controller bytes pass unless the write is refused
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            media_wr_byte <= 8'h00;
            media_wr_en <= 1'b0;
        end else begin
            media_wr_byte <= (wg_s & ~abort_nxt) ? wr_byte : 8'h00; // see RULE13
            media_wr_en <= wg_s & ~abort_nxt;
        end
    end

    // configuration reply with drive field lengths
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_ack <= 1'b0;
            cfg_len <= 16'h0000;
        end else begin
            cfg_ack <= cfg_req;
            cfg_len <= cfg_req ? fld_len(cfg_sel, wwid_en) : cfg_len; // see RULE3
        end
    end

endmodule : osff_framer

// >>> core/osff_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module osff_pin_sync #(
    parameter int W = 4
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic [W-1:0] pin_in, // raw pin levels
    output logic [W-1:0] pin_out // filtered levels
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_nxt;

    // output follows only when stages two and three agree
    assign out_nxt = (s2_r & s3_r) | (pin_out & (s2_r | s3_r));

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_out <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_out <= out_nxt;
        end
    end

endmodule : osff_pin_sync

// >>> include/osff_pkg.sv
// constants, field lengths and sequencer states for the optical sector format framer
// Notes on behaviour
// RULE1 - sector runs gap, address area, data area, optional post field, speed gap
// RULE2 - controller sizes the intersector gap from configuration minimum and recovery needs
// RULE3 - drive fixes every field length and reports it on a configuration request
// RULE4 - controller reads and verifies the address area before touching the data area
// RULE5 - controller writes zero bytes during both oscillator sync fields
// RULE6 - address sync pattern gives byte alignment; it should hold several set bits
// RULE7 - missed address sync is synthesized for that sector on the next revolution
// RULE8 - controller tolerates a missing sector pulse and waits for the synthesized sync
// RULE9 - optional 32-bit media identifier may lead every address
// RULE10 - flag status bit zero set means second cartridge surface
// RULE11 - address check bytes are withheld when drive guarantees integrity, else controller checks
// RULE12 - write status zero means certified sector; any set bit means defective
// RULE13 - controller may ignore write status, but drive may abort writes to defective sectors
// RULE14 - address pad bytes written by the controller are zeros
// RULE15 - write splice regions of data and post field areas carry zero bytes
// RULE16 - data area oscillator sync may have zero length, then no zeros are sent
// RULE17 - recording pattern marks data start; controller must detect it
// RULE18 - controller recognises the media maker's recording pattern too
// RULE19 - undetected recording pattern is replaced by a synthesized one from the drive
// RULE20 - data field is segments of 128-byte multiples plus 8-byte check multiples
// RULE21 - controller generates and verifies segment check codes
// RULE22 - data pad may be omitted; sent pad and final speed gap are zeros
// RULE23 - controller sequences fields with a byte counter loaded per field length
package osff_pkg;

    // ----------------------------------------------------------------
    // field lengths in bytes, fixed by the drive
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_PLO_LEN = 16'h000C;
    localparam logic [15:0] ADDR_SYNC_WIN = 16'h0004;
    localparam logic [15:0] WWID_LEN = 16'h0004;
    localparam logic [15:0] TRACK_LEN = 16'h0002;
    localparam logic [15:0] SECTOR_LEN = 16'h0001;
    localparam logic [15:0] FLAG_LEN = 16'h0001;
    localparam logic [15:0] ADDR_CHK_LEN = 16'h0002;
    localparam logic [15:0] WSTAT_LEN = 16'h0001;
    localparam logic [15:0] ADDR_PAD_LEN = 16'h0002;
    localparam logic [15:0] SPLICE_LEN = 16'h0002;
    localparam logic [15:0] DATA_PLO_LEN = 16'h000C;
    localparam logic [15:0] DATA_PAT_WIN = 16'h0004;
    localparam logic [15:0] SEG_DATA_LEN = 16'h0200; // 4 x 128
    localparam logic [15:0] SEG_CHK_LEN = 16'h0010; // 2 x 8
    localparam logic [7:0] SEG_NUM = 8'h02;
    localparam logic [15:0] DATA_PAD_LEN = 16'h0002;
    localparam logic [15:0] ABODY_LEN_W = 16'h0008; // id + track + sector + flag
    localparam logic [15:0] ABODY_LEN_N = 16'h0004; // track + sector + flag

    // ----------------------------------------------------------------
    // pattern bytes
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SYNC_PAT = 8'hA1;
    localparam logic [7:0] DATA_PAT = 8'hF8;

    // ----------------------------------------------------------------
    // sequencer states, gray coded along the sector
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_APLO = 4'h1,
        S_ASYNC = 4'h3,
        S_ABODY = 4'h2,
        S_ACHK = 4'h6,
        S_AWST = 4'h7,
        S_APAD = 4'h5,
        S_DSPL = 4'h4,
        S_DPLO = 4'hC,
        S_DPAT = 4'hD,
        S_DDATA = 4'hF,
        S_DCHK = 4'hE,
        S_DPAD = 4'hA
    } osff_state_t;

endpackage : osff_pkg

// >>> testbench/osff_assertions.sv
// concurrent checks on the framer's ports
`timescale 1ns/1ps
module osff_assertions (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic [7:0] media_byte, // media byte
    input wire logic media_valid, // media strobe
    input wire logic [7:0] wr_byte, // controller write byte
    input wire logic cfg_req, // length request
    input wire logic [7:0] rd_byte, // read byte
    input wire logic rd_valid, // read strobe
    input wire logic addr_mark, // address sync pulse
    input wire logic data_mark, // pattern pulse
    input wire logic synth_used, // synthesized mark flag
    input wire logic defect_sector, // defective sector flag
    input wire logic write_abort, // write refused
    input wire logic [7:0] media_wr_byte, // recording byte
    input wire logic media_wr_en, // recording enable
    input wire logic cfg_ack, // length answer
    input wire logic [15:0] cfg_len // length value
);
    import osff_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // configuration answers
    cfg_answer_a: assert property (cfg_req |=> cfg_ack) else $error("length request unanswered");
    cfg_pulse_a: assert property (!cfg_req |=> !cfg_ack) else $error("unrequested length answer");
    cfg_hold_a: assert property (!cfg_req |=> $stable(cfg_len)) else $error("length changed unasked");

    // read link framing
    rd_cause_a: assert property (rd_valid |-> $past(media_valid)) else $error("read byte without media");
    sync_byte_a: assert property (addr_mark |-> rd_valid && rd_byte == ADDR_SYNC_PAT)
        else $error("address mark without sync byte");
    pat_found_a: assert property (data_mark && !synth_used |-> $past(media_byte) == DATA_PAT)
        else $error("pattern mark without pattern byte");

    // recording path
    wr_zero_a: assert property (!media_wr_en |-> media_wr_byte == 8'h00) else $error("idle byte not zero");
    wr_copy_a: assert property (media_wr_en |-> media_wr_byte == $past(wr_byte)) else $error("write byte lost");
    abort_stop_a: assert property (write_abort |=> !media_wr_en) else $error("aborted write recorded");
    abort_cause_a: assert property (write_abort |-> defect_sector) else $error("abort on good sector");

    // main scenarios reached
    cover property (addr_mark && synth_used);
    cover property (data_mark && synth_used);
    cover property ($rose(write_abort));
    cover property (cfg_ack);
endmodule : osff_assertions

// >>> testbench/osff_ctrl_model.sv
// controller-side partner: drives the gates and the write bytes of the framer
`timescale 1ns/1ps
module osff_ctrl_model (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic rd_req, // bench asks for a read pass
    input wire logic wr_req, // bench asks for a write pass
    input wire logic data_zone, // bench marks user data bytes
    input wire logic addr_mark, // address sync seen from drive
    output logic read_gate_pin, // read gate to drive
    output logic write_gate_pin, // write gate to drive
    output logic [7:0] wr_byte // write data to drive
);
    logic addr_seen_r;

    // remember that this sector's address was located before any write
    always_ff @(posedge clk) begin
        if (sys_rst || !(rd_req || wr_req)) begin
            addr_seen_r <= 1'b0;
        end else if (addr_mark) begin
            addr_seen_r <= 1'b1;
        end
    end

    // gates move just after the edge; everything outside user data is zero
    always_ff @(posedge clk) begin
        read_gate_pin <= !sys_rst && rd_req;
        write_gate_pin <= !sys_rst && wr_req && addr_seen_r;
        wr_byte <= (!sys_rst && data_zone) ? 8'($urandom) : 8'h00;
    end
endmodule : osff_ctrl_model

// >>> testbench/tb_top.sv
// self-checking bench for the sector framer with a controller partner
`timescale 1ns/1ps
module tb_top;
    import osff_pkg::*;
    logic clk = 0, sys_rst = 1, index_pin = 0, sector_pin = 0, media_valid = 0;
    logic wwid_en = 0, addr_chk_hide = 0, cfg_req = 0, rd_req = 0, wr_req = 0, data_zone = 0;
    logic [7:0] media_byte = 8'h00;
    osff_state_t cfg_sel = S_IDLE;
    logic read_gate_pin, write_gate_pin, rd_valid, addr_mark, data_mark, synth_used;
    logic defect_sector, write_abort, media_wr_en, cfg_ack;
    logic [7:0] wr_byte, rd_byte, media_wr_byte, sector_num;
    logic [15:0] cfg_len;
    logic [7:0] rd_q[$];
    logic [15:0] cfg_q[$];
    int errors = 0, check_count = 0, marks = 0, cycles = 0;

    always #2 clk = ~clk;

    osff_framer osff_framer_i (.clk, .sys_rst, .index_pin, .sector_pin, .read_gate_pin, .write_gate_pin,
        .media_byte, .media_valid, .wr_byte, .wwid_en, .addr_chk_hide, .cfg_req, .cfg_sel, .rd_byte,
        .rd_valid, .addr_mark, .data_mark, .synth_used, .defect_sector, .write_abort, .media_wr_byte,
        .media_wr_en, .sector_num, .cfg_ack, .cfg_len);
    osff_ctrl_model osff_ctrl_model_i (.clk, .sys_rst, .rd_req, .wr_req, .data_zone, .addr_mark,
        .read_gate_pin, .write_gate_pin, .wr_byte);

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [15:0] len_of(osff_state_t s);
        case (s)
            S_APLO: return ADDR_PLO_LEN;
            S_ASYNC: return ADDR_SYNC_WIN;
            S_ABODY: return wwid_en ? ABODY_LEN_W : ABODY_LEN_N;
            S_ACHK: return ADDR_CHK_LEN;
            S_AWST: return WSTAT_LEN;
            S_APAD: return ADDR_PAD_LEN;
            S_DSPL: return SPLICE_LEN;
            S_DPLO: return DATA_PLO_LEN;
            S_DPAT: return DATA_PAT_WIN;
            S_DDATA: return SEG_DATA_LEN;
            S_DCHK: return SEG_CHK_LEN;
            default: return DATA_PAD_LEN;
        endcase
    endfunction : len_of

    task automatic pulse(ref logic p);
        p = 1'b1;
        repeat (6) @(negedge clk);
        p = 1'b0;
        repeat (6) @(negedge clk);
    endtask : pulse

    // one media byte; passed bytes are noted for the read monitor
    task automatic feed(logic [7:0] b, bit pass);
        @(negedge clk);
        media_byte = b;
        media_valid = 1'b1;
        if (pass) begin
            rd_q.push_back(b);
        end
        @(negedge clk);
        media_valid = 1'b0;
        media_byte = ~b;
    endtask : feed

    // sync: 0 missed, 1 recorded, 2 left to the drive to synthesize
    task automatic sector(int sync, logic [7:0] wst, bit pat, bit wr);
        marks = 0;
        rd_req = 1'b1;
        repeat (8) @(negedge clk);
        pulse(sector_pin);
        chk("sector_num", 16'h0001, 16'(sector_num));
        repeat (12) feed(8'h00, 0);
        if (sync == 0) begin
            repeat (4) feed(8'h00, 0);
        end else begin
            if (sync == 2) begin
                rd_q.push_back(ADDR_SYNC_PAT);
            end
            feed(sync == 1 ? ADDR_SYNC_PAT : 8'h00, sync == 1);
            repeat (wwid_en ? 7 : 3) feed(8'($urandom), 1);
            feed(8'h01, 1); // flag marking the second surface
            repeat (2) feed(8'($urandom), !addr_chk_hide);
            feed(wst, 1);
            wr_req = wr;
            repeat (16) feed(8'h00, 0);
            if (wr) begin
                data_zone = 1'b1;
                repeat (20) @(negedge clk);
                chk("write_abort", 16'(wst != 0), 16'(write_abort));
                chk("defect_sector", 16'(wst != 0), 16'(defect_sector));
                chk("media_wr_en", 16'(wst == 0), 16'(media_wr_en));
                data_zone = 1'b0;
            end else begin
                if (pat) begin
                    feed(DATA_PAT, 1); // maker's pattern presented on the link
                end else begin
                    repeat (3) feed(8'h00, 0);
                    rd_q.push_back(DATA_PAT); // substitute pattern on the last window byte
                    feed(8'h00, 0);
                end
                repeat (2) begin
                    repeat (512) feed(8'($urandom), 1);
                    repeat (16) feed(8'($urandom), 1); // segment check bytes
                end
                repeat (2) feed(8'h00, 0);
                chk("data_mark", 16'h0001, 16'(marks));
                chk("synth_used", 16'(!pat), 16'(synth_used));
            end
        end
        rd_req = 1'b0;
        wr_req = 1'b0;
        repeat (20) @(negedge clk); // gap before the next sector
        chk("rd_pending", 16'h0000, 16'(rd_q.size()));
        $display("sector test done sync %0d write %0d", sync, wr);
    endtask : sector

    // monitor: compares each presented result with the oldest note
    always @(negedge clk) begin
        cycles++;
        if (data_mark === 1'b1) begin
            marks++;
        end
        if (rd_valid === 1'b1) begin
            if (rd_q.size() == 0) begin
                chk("rd_extra", 16'h0000, 16'h0001);
            end else begin
                chk("rd_byte", 16'(rd_q.pop_front()), 16'(rd_byte));
            end
        end
        if (cfg_ack === 1'b1) begin
            chk("cfg_len", cfg_q.size() ? cfg_q.pop_front() : 16'hFFFF, cfg_len);
        end
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        osff_state_t s;
        void'($urandom(91));
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        for (int w = 0; w < 2; w++) begin
            wwid_en = w[0];
            s = S_APLO;
            repeat (12) begin
                @(negedge clk);
                cfg_req = 1'b1;
                cfg_sel = s;
                cfg_q.push_back(len_of(s));
                s = s.next();
            end
            @(negedge clk);
            cfg_req = 1'b0;
            repeat (4) @(negedge clk);
            chk("cfg_pending", 16'h0000, 16'(cfg_q.size()));
        end
        $display("config test done");
        wwid_en = 1'b1;
        pulse(index_pin);
        sector(1, 8'h00, 1, 0);
        wwid_en = 1'b0;
        addr_chk_hide = 1'b1;
        pulse(index_pin);
        sector(0, 8'h00, 1, 0);
        pulse(index_pin); // next revolution, same sector
        sector(2, 8'h00, 0, 0);
        addr_chk_hide = 1'b0;
        pulse(index_pin);
        sector(1, 8'h00, 1, 1);
        pulse(index_pin);
        sector(1, 8'($urandom) | 8'h01, 1, 1);
        report_and_stop();
    end
endmodule : tb_top

bind osff_framer osff_assertions osff_assertions_i (.clk, .sys_rst, .media_byte, .media_valid, .wr_byte,
    .cfg_req, .rd_byte, .rd_valid, .addr_mark, .data_mark, .synth_used, .defect_sector, .write_abort,
    .media_wr_byte, .media_wr_en, .cfg_ack, .cfg_len);
